// *** sleep_pkg.sv ***
package sleep_pkg;
    // regulator select encodings
    localparam logic REG_LOW_POWER = 1'b1;
    localparam logic REG_NORMAL = 1'b0;
    // extra wake delay for low-power regulator, in ns
    localparam int LP_WAKE_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int LP_WAKE_CYC = (LP_WAKE_NS / CLK_NS) < 1 ? 1 : (LP_WAKE_NS / CLK_NS);
    // forced no-op cycles before vectoring
    localparam int FORCED_NOP_CYC = 2;
    localparam int CNT_W = 12;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE,
        ST_SLEEP,
        ST_SETTLE,
        ST_RESUME,
        ST_NOPS
    } state_t;

    typedef struct packed {
        logic low_freq;
        logic high_freq;
        logic secondary;
    } osc_t;

    typedef struct packed {
        logic external_reset_pin;
        logic brownout_reset;
        logic power_on_reset;
        logic watchdog_timer;
        logic interrupt;
    } wake_t;
endpackage

// *** sleep_mode_controller.sv ***
`timescale 1ns/1ps
module sleep_mode_controller #(
    parameter int PORT_W = 8,
    parameter int LP_WAKE = sleep_pkg::LP_WAKE_CYC,
    parameter int NOPS = sleep_pkg::FORCED_NOP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sleep_exec,
    input wire logic idle_select,
    input wire logic regulator_power_select,
    input wire logic global_interrupt_enable,
    input wire logic int_pending,
    input wire sleep_pkg::wake_t wake_src,
    input wire sleep_pkg::wake_t wake_enable,
    input wire sleep_pkg::osc_t osc_request,
    input wire sleep_pkg::osc_t osc_force,
    input wire logic converter_on,
    input wire logic converter_rc_clock,
    input wire logic [PORT_W-1:0] port_drive,
    input wire logic [PORT_W-1:0] port_oe,
    input wire logic [PORT_W-1:0] port_periph_active,
    output logic cpu_clk_en,
    output logic sys_clk_en,
    output logic periph_clk_en,
    output sleep_pkg::osc_t osc_enable,
    output logic converter_run,
    output logic converter_abort,
    output logic converter_on_q,
    output logic watchdog_clear,
    output logic power_down_flag,
    output logic timeout_flag,
    output logic device_reset,
    output logic regulator_low_power,
    output logic resume_next,
    output logic forced_nop,
    output logic vector_take,
    output logic [PORT_W-1:0] port_hold_q,
    output logic [PORT_W-1:0] port_hold_oe_q,
    output logic [PORT_W-1:0] port_hold_en
);
    sleep_pkg::state_t state_q, state_d;
    logic [sleep_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic pd_q, pd_d, to_q, to_d, wdc_q, wdc_d, abort_q, abort_d, rst_q, rst_d;
    logic resume_q, resume_d, nop_q, nop_d, vec_q, vec_d, cvon_q, cvon_d;
    logic [PORT_W-1:0] hold_q, hold_d, hoe_q, hoe_d;
    sleep_pkg::osc_t osc_q, osc_d;
    logic reset_wake, soft_wake, any_int;

    always_comb begin
        reset_wake = (wake_src.external_reset_pin & wake_enable.external_reset_pin)
            | (wake_src.brownout_reset & wake_enable.brownout_reset)
            | wake_src.power_on_reset;
        soft_wake = (wake_src.watchdog_timer & wake_enable.watchdog_timer)
            | (wake_src.interrupt & wake_enable.interrupt) | int_pending;
        any_int = wake_src.interrupt | int_pending;
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pd_d = pd_q;
        to_d = to_q;
        wdc_d = 1'b0;
        abort_d = 1'b0;
        rst_d = 1'b0;
        resume_d = 1'b0;
        nop_d = 1'b0;
        vec_d = 1'b0;
        cvon_d = converter_on;
        hold_d = hold_q;
        hoe_d = hoe_q;
        osc_d = osc_q;
        case (state_q)
            sleep_pkg::ST_RUN: begin
                osc_d = '1;
                if (sleep_exec && !int_pending) begin
                    if (idle_select) begin
                        state_d = sleep_pkg::ST_IDLE;
                    end else begin
                        state_d = sleep_pkg::ST_SLEEP;
                        wdc_d = 1'b1;
                        pd_d = 1'b0;
                        to_d = 1'b1;
                        abort_d = converter_on && !converter_rc_clock;
                        hold_d = port_drive;
                        hoe_d = port_oe;
                        osc_d = osc_request | osc_force;
                    end
                end
            end
            sleep_pkg::ST_IDLE: begin
                if (reset_wake) begin
                    state_d = sleep_pkg::ST_RUN;
                    rst_d = 1'b1;
                end else if (any_int || (wake_src.watchdog_timer && wake_enable.watchdog_timer)) begin
                    state_d = sleep_pkg::ST_RESUME;
                end
            end
            sleep_pkg::ST_SLEEP: begin
                osc_d = osc_request | osc_force;
                if (reset_wake || soft_wake) begin
                    wdc_d = 1'b1;
                    if (reset_wake) begin
                        state_d = sleep_pkg::ST_RUN;
                        rst_d = 1'b1;
                    end else if (regulator_power_select == sleep_pkg::REG_LOW_POWER) begin
                        state_d = sleep_pkg::ST_SETTLE;
                        cnt_d = sleep_pkg::CNT_W'(LP_WAKE - 1);
                    end else begin
                        state_d = sleep_pkg::ST_RESUME;
                    end
                end
            end
            sleep_pkg::ST_SETTLE: begin
                if (reset_wake) begin
                    state_d = sleep_pkg::ST_RUN;
                    rst_d = 1'b1;
                end else if (cnt_q == '0) begin
                    state_d = sleep_pkg::ST_RESUME;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            sleep_pkg::ST_RESUME: begin
                resume_d = 1'b1;
                if (global_interrupt_enable && any_int) begin
                    state_d = sleep_pkg::ST_NOPS;
                    cnt_d = sleep_pkg::CNT_W'(NOPS - 1);
                end else begin
                    state_d = sleep_pkg::ST_RUN;
                end
            end
            sleep_pkg::ST_NOPS: begin
                nop_d = 1'b1;
                if (cnt_q == '0) begin
                    state_d = sleep_pkg::ST_RUN;
                    vec_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: state_d = sleep_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= sleep_pkg::ST_RUN;
            cnt_q <= '0;
            pd_q <= 1'b1;
            to_q <= 1'b1;
            wdc_q <= 1'b0;
            abort_q <= 1'b0;
            rst_q <= 1'b0;
            resume_q <= 1'b0;
            nop_q <= 1'b0;
            vec_q <= 1'b0;
            cvon_q <= 1'b0;
            hold_q <= '0;
            hoe_q <= '0;
            osc_q <= '1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pd_q <= pd_d;
            to_q <= to_d;
            wdc_q <= wdc_d;
            abort_q <= abort_d;
            rst_q <= rst_d;
            resume_q <= resume_d;
            nop_q <= nop_d;
            vec_q <= vec_d;
            cvon_q <= cvon_d;
            hold_q <= hold_d;
            hoe_q <= hoe_d;
            osc_q <= osc_d;
        end
    end

    logic asleep_d, cpu_en_q, cpu_en_d, sys_en_q, sys_en_d, crun_q, crun_d, lp_q, lp_d;
    logic [PORT_W-1:0] hen_q, hen_d;
    always_comb begin
        asleep_d = (state_d == sleep_pkg::ST_SLEEP) || (state_d == sleep_pkg::ST_SETTLE);
        cpu_en_d = !asleep_d && (state_d != sleep_pkg::ST_IDLE);
        sys_en_d = !asleep_d;
        // rc-clocked converter keeps converting through sleep
        crun_d = converter_on && (!asleep_d || converter_rc_clock);
        lp_d = (state_d == sleep_pkg::ST_SLEEP) && (regulator_power_select == sleep_pkg::REG_LOW_POWER);
        hen_d = (state_d == sleep_pkg::ST_SLEEP) ? ~port_periph_active : '0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_en_q <= 1'b1;
            sys_en_q <= 1'b1;
            crun_q <= 1'b0;
            lp_q <= 1'b0;
            hen_q <= '0;
        end else begin
            cpu_en_q <= cpu_en_d;
            sys_en_q <= sys_en_d;
            crun_q <= crun_d;
            lp_q <= lp_d;
            hen_q <= hen_d;
        end
    end

    assign cpu_clk_en = cpu_en_q;
    assign sys_clk_en = sys_en_q;
    assign periph_clk_en = sys_en_q;
    assign osc_enable = osc_q;
    assign converter_run = crun_q;
    assign converter_abort = abort_q;
    assign converter_on_q = cvon_q;
    assign watchdog_clear = wdc_q;
    assign power_down_flag = pd_q;
    assign timeout_flag = to_q;
    assign device_reset = rst_q;
    assign regulator_low_power = lp_q;
    assign resume_next = resume_q;
    assign forced_nop = nop_q;
    assign vector_take = vec_q;
    assign port_hold_q = hold_q;
    assign port_hold_oe_q = hoe_q;
    assign port_hold_en = hen_q;

    noop_sleep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_RUN && sleep_exec && int_pending) |=> $stable(pd_q) && !wdc_q && $stable(to_q))
        else $error("pending interrupt did not make sleep a no-op");
    enter_flags_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_RUN && sleep_exec && !int_pending && !idle_select) |=> !pd_q && to_q && wdc_q)
        else $error("sleep entry flags wrong");
    idle_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_RUN && sleep_exec && !int_pending && idle_select) |=> state_q == sleep_pkg::ST_IDLE)
        else $error("idle not entered");
    clk_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_SLEEP) |-> !cpu_clk_en && !sys_clk_en)
        else $error("clocks run in sleep");
    wake_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_SLEEP && (reset_wake || soft_wake)) |=> wdc_q)
        else $error("wake did not clear watchdog");
    lp_settle_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_SLEEP && !reset_wake && soft_wake && regulator_power_select)
        |=> state_q == sleep_pkg::ST_SETTLE)
        else $error("low-power wake skipped settling");
    fast_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_SLEEP && !reset_wake && soft_wake && !regulator_power_select)
        |=> state_q == sleep_pkg::ST_RESUME)
        else $error("normal wake delayed");
    conv_abort_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == sleep_pkg::ST_RUN && sleep_exec && !int_pending && !idle_select && converter_on
        && !converter_rc_clock) |=> converter_abort && converter_on_q)
        else $error("converter not aborted");
endmodule

// *** core_model.sv ***
`timescale 1ns/1ps
// counts what the core sees on each wake and sleep entry
module core_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic resume_next,
    input wire logic forced_nop,
    input wire logic vector_take,
    input wire logic watchdog_clear,
    input wire logic converter_abort,
    input wire logic device_reset,
    output logic [7:0] resumes,
    output logic [7:0] nops,
    output logic [7:0] vectors,
    output logic [7:0] wd_clears,
    output logic [7:0] aborts,
    output logic [7:0] resets,
    output logic order_bad
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {resumes, nops, vectors, wd_clears, aborts, resets} <= '0;
            order_bad <= 1'b0;
        end else if (clr) begin
            {resumes, nops, vectors, wd_clears, aborts, resets} <= '0;
            order_bad <= 1'b0;
        end else begin
            resumes <= resumes + {7'h00, resume_next};
            nops <= nops + {7'h00, forced_nop};
            vectors <= vectors + {7'h00, vector_take};
            wd_clears <= wd_clears + {7'h00, watchdog_clear};
            aborts <= aborts + {7'h00, converter_abort};
            resets <= resets + {7'h00, device_reset};
            // vectoring only after forced no-ops
            order_bad <= order_bad | (vector_take & (nops == 8'h00));
        end
    end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    localparam int LP = 10;
    logic ref_clk, rst, sleep_exec, idle_select, regulator_power_select, global_interrupt_enable, int_pending;
    sleep_pkg::wake_t wake_src, wake_enable;
    sleep_pkg::osc_t osc_request, osc_force, osc_enable;
    logic converter_on, converter_rc_clock, clr, order_bad;
    logic [7:0] port_drive, port_oe, port_periph_active, port_hold_q, port_hold_oe_q, port_hold_en;
    logic cpu_clk_en, sys_clk_en, periph_clk_en, converter_run, converter_abort, converter_on_q, watchdog_clear;
    logic power_down_flag, timeout_flag, device_reset, regulator_low_power, resume_next, forced_nop, vector_take;
    logic [7:0] resumes, nops, vectors, wd_clears, aborts, resets;
    logic [4:0] srcs [4] = '{5'h10, 5'h08, 5'h04, 5'h02};
    int err_count = 0, total_checks = 0, cycles = 0, n_norm, n_lp, n;

    sleep_mode_controller #(.LP_WAKE(LP)) sleep_mode_controller_inst (
        .ref_clk(ref_clk), .rst(rst), .sleep_exec(sleep_exec), .idle_select(idle_select),
        .regulator_power_select(regulator_power_select), .global_interrupt_enable(global_interrupt_enable),
        .int_pending(int_pending), .wake_src(wake_src), .wake_enable(wake_enable),
        .osc_request(osc_request), .osc_force(osc_force), .converter_on(converter_on),
        .converter_rc_clock(converter_rc_clock), .port_drive(port_drive), .port_oe(port_oe),
        .port_periph_active(port_periph_active), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
        .periph_clk_en(periph_clk_en), .osc_enable(osc_enable), .converter_run(converter_run),
        .converter_abort(converter_abort), .converter_on_q(converter_on_q), .watchdog_clear(watchdog_clear),
        .power_down_flag(power_down_flag), .timeout_flag(timeout_flag), .device_reset(device_reset),
        .regulator_low_power(regulator_low_power), .resume_next(resume_next), .forced_nop(forced_nop),
        .vector_take(vector_take), .port_hold_q(port_hold_q), .port_hold_oe_q(port_hold_oe_q),
        .port_hold_en(port_hold_en)
    );
    core_model core_model_inst (
        .ref_clk(ref_clk), .rst(rst), .clr(clr), .resume_next(resume_next), .forced_nop(forced_nop),
        .vector_take(vector_take), .watchdog_clear(watchdog_clear), .converter_abort(converter_abort),
        .device_reset(device_reset), .resumes(resumes), .nops(nops), .vectors(vectors),
        .wd_clears(wd_clears), .aborts(aborts), .resets(resets), .order_bad(order_bad)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("Error at %0t: cycle count %0h reached limit %0h", $time, cycles, 20000);
            end_sim;
        end
    end

    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    task sleep_cmd;
        clr = 1'b1;
        sleep_exec = 1'b1;
        cyc(1);
        clr = 1'b0;
        sleep_exec = 1'b0;
        cyc(2);
    endtask

    // waits for the core clock to return, counting cycles
    task wake(input logic [4:0] src, output int w);
        w = 0;
        wake_src = sleep_pkg::wake_t'(src);
        while (cpu_clk_en !== 1'b1 && w < 300) begin
            cyc(1);
            w++;
        end
        wake_src = sleep_pkg::wake_t'(5'h00);
        cyc(6);
        int_pending = 1'b0;
    endtask

    initial begin
        {rst, sleep_exec, idle_select, regulator_power_select, global_interrupt_enable, int_pending} = 6'h20;
        {clr, converter_rc_clock, converter_on} = 3'h1;
        wake_src = sleep_pkg::wake_t'(5'h00);
        wake_enable = sleep_pkg::wake_t'(5'h1F);
        osc_request = sleep_pkg::osc_t'(3'h4);
        osc_force = sleep_pkg::osc_t'(3'h1);
        {port_drive, port_oe, port_periph_active} = {8'hA5, 8'h0F, 8'h30};
        cyc(6);
        rst = 1'b0;
        cyc(1);
        chk({cpu_clk_en, sys_clk_en, periph_clk_en, osc_enable, power_down_flag, timeout_flag}, 8'hFF);
        int_pending = 1'b1;
        sleep_cmd;
        chk({power_down_flag, timeout_flag, cpu_clk_en, wd_clears}, {3'h7, 8'h00});
        int_pending = 1'b0;
        sleep_cmd;
        port_drive = 8'h5A;
        cyc(1);
        chk({power_down_flag, timeout_flag, cpu_clk_en, sys_clk_en}, 4'h4);
        chk(osc_enable, 3'h5);
        chk({converter_run, converter_on_q, aborts, wd_clears}, {2'h1, 8'h01, 8'h01});
        chk({port_hold_en, port_hold_q & 8'hCF, port_hold_oe_q & 8'hCF}, 24'hCF850F);
        chk(regulator_low_power, 1'b0);
        global_interrupt_enable = 1'b1;
        int_pending = 1'b1;
        wake(5'h01, n_norm);
        chk({resumes, nops, vectors, wd_clears, 7'h00, order_bad}, 40'h0102010200);
        global_interrupt_enable = 1'b0;
        // low-power only with interrupt wake in use
        regulator_power_select = 1'b1;
        converter_rc_clock = 1'b1;
        sleep_cmd;
        chk({regulator_low_power, converter_run, aborts}, 10'h300);
        int_pending = 1'b1;
        wake(5'h01, n_lp);
        chk({n_lp - n_norm >= LP, n_norm < LP}, 2'h3);
        chk({resumes, nops, vectors}, 24'h010000);
        regulator_power_select = 1'b0;
        wake_enable = sleep_pkg::wake_t'(5'h1D);
        sleep_cmd;
        wake_src = sleep_pkg::wake_t'(5'h02);
        cyc(5);
        chk(cpu_clk_en, 1'b0);
        wake_src = sleep_pkg::wake_t'(5'h00);
        wake_enable = sleep_pkg::wake_t'(5'h1B);
        // first pass: still asleep, so sleep_exec is refused and only the wake clears
        for (int i = 0; i < 4; i++) begin
            sleep_cmd;
            wake(srcs[i], n);
            chk({resets, resumes, wd_clears}, {(i < 3) ? 8'h01 : 8'h00, (i < 3) ? 8'h00 : 8'h01,
                (i == 0) ? 8'h01 : 8'h02});
        end
        idle_select = 1'b1;
        sleep_cmd;
        chk({cpu_clk_en, periph_clk_en}, 2'h1);
        int_pending = 1'b1;
        wake(5'h01, n);
        chk({cpu_clk_en, n < 300}, 2'h3);
        end_sim;
    end
endmodule
